// ---- shared/ssb_pkg.sv ----
// Constants, types and a helper function for the sensor status and burst register block
package ssb_pkg;

  // Register offsets (7-bit address space of the serial port)
  localparam logic [6:0] ADDR_ACTIVITY = 7'h3D;
  localparam logic [6:0] ADDR_RESERVED = 7'h3E;
  localparam logic [6:0] ADDR_COMPL_CODE = 7'h3F;
  localparam logic [6:0] ADDR_PIXEL_PORT = 7'h40;
  localparam logic [6:0] ADDR_MOTION_PORT = 7'h50;
  localparam logic [6:0] ADDR_FW_PORT = 7'h60;

  // Activity flag field positions and reset value
  localparam int FLAG_FW_RUNNING = 7;
  localparam int FLAG_PD_PULSE = 5;
  localparam int FLAG_FRAME_A = 1;
  localparam int FLAG_FRAME_B = 0;
  localparam logic [7:0] ACTIVITY_RESET = 8'h00;
  localparam logic [7:0] ACTIVITY_IMPL_MASK = 8'hA3;

  // Serial framing: first bit of the address byte selects a write
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Burst sizes
  localparam logic [2:0] MOTION_BYTES = 3'h7;
  localparam int PIXELS_PER_FRAME = 900;
  localparam int PIXEL_BURST_TOTAL = PIXELS_PER_FRAME + (PIXELS_PER_FRAME * 2) / 3;

  // Least gap the host leaves between address byte and first read bit
  localparam int ADDR_READ_GAP_NS = 50;
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int ADDR_READ_GAP_CYC = (ADDR_READ_GAP_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  // Byte captured on the link, tagged when it is the first of its frame
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } ssb_rx_word_t;

  // Motion report presented by the navigation core, sent in this order
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] delta_x;
    logic [7:0] delta_y;
    logic [7:0] surface_quality;
    logic [7:0] shutter_hi;
    logic [7:0] shutter_lo;
    logic [7:0] max_pixel;
  } ssb_motion_t;

  // Operating modes of the register engine
  typedef enum logic [2:0] {
    MD_IDLE = 3'b000,
    MD_WRITE = 3'b001,
    MD_READ = 3'b010,
    MD_PIXEL = 3'b011,
    MD_MOTION = 3'b100,
    MD_FIRMWARE = 3'b101
  } ssb_mode_t;

  // Picks byte n of a motion report, zero past the end
  function automatic logic [7:0] ssb_motion_byte(input ssb_motion_t rep, input logic [2:0] n);
    logic [7:0] b;
    b = 8'h00;
    case (n)
      3'h0: b = rep.status;
      3'h1: b = rep.delta_x;
      3'h2: b = rep.delta_y;
      3'h3: b = rep.surface_quality;
      3'h4: b = rep.shutter_hi;
      3'h5: b = rep.shutter_lo;
      3'h6: b = rep.max_pixel;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

endpackage

// ---- hdl/ssb_buf2.sv ----
// Small valid/ready buffer built from flip-flops
`timescale 1ns/1ps
module ssb_buf2 import ssb_pkg::*; #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;

  // Handshake terms
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];

  // Pointer wrap shared by both ends
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Pointers and fill level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage needs no reset; valid guards every read
  always_ff @(posedge core_clk) begin
    if (push) store[wr_ptr] <= in_data;
  end

endmodule

// ---- hdl/ssb_link.sv ----
// Serial link engine clocked by the host's serial clock
`timescale 1ns/1ps
module ssb_link import ssb_pkg::*; (
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic rst_n,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output ssb_rx_word_t rx_word,
  output logic rx_tgl,
  output logic ld_tgl,
  output logic miso,
  output logic miso_oe
);
  // Deselect ends the frame; the clock may stand still outside it
  wire frame_rst = chip_select_n || !rst_n;

  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic got_byte;
  logic rd_mode;
  logic [7:0] shift_out;

  wire byte_done = (bit_cnt == BIT_LAST);
  wire load_now = (bit_cnt == 3'h0) && got_byte && rd_mode;

  // Input shifter, sampled on the rising edge
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
      got_byte <= 1'b0;
      rd_mode <= 1'b0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= {shift_in[5:0], mosi};
      if (byte_done) begin
        got_byte <= 1'b1;
        if (!got_byte) rd_mode <= !shift_in[6];
      end
    end
  end

  // Word and toggle survive deselect so the core never sees a false event
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word <= '0;
      rx_tgl <= 1'b0;
    end else if (byte_done) begin
      rx_word <= '{first: !got_byte, data: {shift_in, mosi}};
      rx_tgl <= !rx_tgl;
    end
  end

  // Output shifter changes on the falling edge, one byte per eight clocks
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      shift_out <= 8'h00;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= rd_mode;
      if (load_now) begin
        miso <= tx_byte[7];
        shift_out <= {tx_byte[6:0], 1'b0};
      end else begin
        miso <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // Each delivered byte tells the core to prepare the next
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) ld_tgl <= 1'b0;
    else if (load_now && !chip_select_n) ld_tgl <= !ld_tgl;
  end

endmodule

// ---- hdl/ssb_top.sv ----
// Upper register bank of the motion sensor: activity flags, part code and burst ports
`timescale 1ns/1ps
module ssb_top import ssb_pkg::*; #(
  parameter logic [7:0] PART_CODE = 8'h5A, // Arbitrary value
  parameter int PIXEL_TOTAL = PIXEL_BURST_TOTAL
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic power_down_n,
  input wire logic frame_tick,
  input wire logic firmware_running,
  input wire ssb_motion_t motion_report,
  input wire logic [7:0] pixel_data,
  output logic [10:0] pixel_index,
  output logic [7:0] fw_byte,
  output logic fw_valid,
  output logic link_overrun
);
  localparam logic [10:0] PIX_LAST = 11'(PIXEL_TOTAL);

  // Link side
  ssb_rx_word_t rx_word;
  logic rx_tgl;
  logic ld_tgl;
  logic [7:0] tx_byte;

  ssb_link u_link (
    .sclk(sclk),
    .chip_select_n(chip_select_n),
    .rst_n(rst_n),
    .mosi(mosi),
    .tx_byte(tx_byte),
    .rx_word(rx_word),
    .rx_tgl(rx_tgl),
    .ld_tgl(ld_tgl),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  // Crossing flops: stage 0 is read only by stage 1
  logic [2:0] rx_sync;
  logic [2:0] ld_sync;
  logic [2:0] pd_sync;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync <= 3'h0;
      ld_sync <= 3'h0;
      pd_sync <= 3'h7;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_tgl};
      ld_sync <= {ld_sync[1:0], ld_tgl};
      pd_sync <= {pd_sync[1:0], power_down_n};
    end
  end

  // Event decode after synchronisation
  wire rx_evt = rx_sync[2] ^ rx_sync[1];
  wire ld_evt = ld_sync[2] ^ ld_sync[1];
  wire pd_pulse = !pd_sync[2] && pd_sync[1]; // End of a low pulse

  // Received bytes queue here; the engine takes one every other cycle
  logic buf_ready;
  logic buf_valid;
  ssb_rx_word_t buf_word;
  logic hold;
  wire take = buf_valid && !hold;

  ssb_buf2 #(
    .WIDTH($bits(ssb_rx_word_t)),
    .DEPTH(2)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(rx_evt),
    .in_ready(buf_ready),
    .in_data(rx_word),
    .out_valid(buf_valid),
    .out_ready(!hold),
    .out_data(buf_word)
  );

  // Engine state
  ssb_mode_t mode;
  logic [6:0] addr;
  logic [7:0] flags;
  logic [7:0] rd_val;
  logic [2:0] mot_idx;
  ssb_motion_t snap;

  // Address decode of a received command byte
  wire is_first = take && buf_word.first;
  wire is_write_cmd = buf_word.data[CMD_WRITE_BIT];
  wire [6:0] cmd_addr = buf_word.data[6:0];
  wire data_byte = take && !buf_word.first;
  wire wr_act = data_byte && (mode == MD_WRITE) && (addr == ADDR_ACTIVITY);
  wire fw_take = data_byte && (mode == MD_FIRMWARE);

  // Plain register read value; reserved and unmapped addresses read zero
  wire [7:0] plain_read = (cmd_addr == ADDR_ACTIVITY) ? flags :
                          (cmd_addr == ADDR_COMPL_CODE) ? ~PART_CODE :
                          8'h00;

  // Next mode for a command byte
  wire ssb_mode_t cmd_mode = is_write_cmd ? ((cmd_addr == ADDR_FW_PORT) ? MD_FIRMWARE : MD_WRITE) :
                             (cmd_addr == ADDR_PIXEL_PORT) ? MD_PIXEL :
                             (cmd_addr == ADDR_MOTION_PORT) ? MD_MOTION : MD_READ;

  // Flag sets win over a clearing write in the same cycle
  wire [7:0] set_bits = {firmware_running, 1'b0, pd_pulse, 3'b000, frame_tick, frame_tick};
  wire [7:0] next_flags = ((wr_act ? buf_word.data : flags) | set_bits) & ACTIVITY_IMPL_MASK;

  // Byte offered to the link for the next load
  wire pix_done = (pixel_index >= PIX_LAST);
  wire [7:0] next_tx = (mode == MD_PIXEL) ? (pix_done ? 8'h00 : pixel_data) :
                       (mode == MD_MOTION) ? ssb_motion_byte(snap, mot_idx) :
                       (mode == MD_READ) ? rd_val : 8'h00;

  // Flags and the offered byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= ACTIVITY_RESET;
      tx_byte <= 8'h00;
      hold <= 1'b0;
      link_overrun <= 1'b0;
    end else begin
      flags <= next_flags;
      tx_byte <= next_tx;
      hold <= take;
      link_overrun <= link_overrun || (rx_evt && !buf_ready);
    end
  end

  // Command and data handling
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MD_IDLE;
      addr <= 7'h00;
      rd_val <= 8'h00;
      snap <= '0;
    end else if (is_first) begin
      mode <= cmd_mode;
      addr <= cmd_addr;
      rd_val <= plain_read;
      if (cmd_mode == MD_MOTION) snap <= motion_report;
    end else if (data_byte && mode == MD_WRITE) begin
      mode <= MD_IDLE;
    end
  end

  // Burst pointers step once per delivered byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_index <= 11'h000;
      mot_idx <= 3'h0;
    end else if (is_first) begin
      pixel_index <= 11'h000;
      mot_idx <= 3'h0;
    end else if (ld_evt && mode == MD_PIXEL && !pix_done) begin
      pixel_index <= pixel_index + 11'h001;
    end else if (ld_evt && mode == MD_MOTION && mot_idx < MOTION_BYTES) begin
      mot_idx <= mot_idx + 3'h1;
    end
  end

  // Firmware stream out; each byte a one-cycle strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fw_byte <= 8'h00;
      fw_valid <= 1'b0;
    end else begin
      fw_valid <= fw_take;
      if (fw_take) fw_byte <= buf_word.data;
    end
  end

  // Checks on the core domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_read_cmd(logic [6:0] a);
    is_first && !is_write_cmd && cmd_addr == a;
  endsequence

  sequence s_two_cycles;
    ##2 1'b1;
  endsequence

  // Burst byte handed over while the port stays selected
  sequence s_burst_step(ssb_mode_t m);
    ld_evt && mode == m && !is_first;
  endsequence

  // Data byte of a plain write to address a
  sequence s_write_data(logic [6:0] a);
    data_byte && mode == MD_WRITE && addr == a;
  endsequence

  // No flag source active, so only the write decides the flags
  sequence s_quiet_sets;
    set_bits == 8'h00;
  endsequence

  a_frame_flags: assert property (frame_tick |=> flags[FLAG_FRAME_A] && flags[FLAG_FRAME_B])
    else $error("frame flags not set after frame tick");

  a_pd_flag: assert property (pd_pulse |=> flags[FLAG_PD_PULSE])
    else $error("power-down pulse not flagged");

  a_fw_running: assert property (firmware_running |=> flags[FLAG_FW_RUNNING])
    else $error("firmware running flag missing");

  a_flags_sticky: assert property (!wr_act |=> (flags & $past(flags)) == $past(flags))
    else $error("activity flag dropped without a write");

  a_flag_reserved: assert property ((flags & ~ACTIVITY_IMPL_MASK) == 8'h00)
    else $error("reserved activity bit set");

  a_compl_code: assert property (s_read_cmd(ADDR_COMPL_CODE) |-> s_two_cycles ##0 tx_byte == ~PART_CODE)
    else $error("complemented part code wrong");

  a_rsvd_addr: assert property (s_read_cmd(ADDR_RESERVED) |-> ##2 tx_byte == 8'h00)
    else $error("reserved address not zero");

  a_pixel_start: assert property (s_read_cmd(ADDR_PIXEL_PORT) |=> mode == MD_PIXEL && pixel_index == 11'h000)
    else $error("pixel burst did not start at index zero");

  a_pixel_step: assert property (ld_evt && mode == MD_PIXEL && !pix_done && !is_first
    |=> pixel_index == $past(pixel_index) + 11'h001)
    else $error("pixel index did not advance");

  a_motion_order: assert property (ld_evt && mode == MD_MOTION && mot_idx < 3'h6 && !is_first
    |=> mot_idx == $past(mot_idx) + 3'h1 ##1 tx_byte == ssb_motion_byte(snap, mot_idx))
    else $error("motion report out of order");

  a_motion_first: assert property (s_read_cmd(ADDR_MOTION_PORT) |-> ##2 tx_byte == $past(motion_report.status, 2))
    else $error("motion burst first byte not status");

  a_fw_stream: assert property (fw_take |=> fw_valid && fw_byte == $past(buf_word.data) ##1 !fw_valid)
    else $error("firmware byte not forwarded");

  // Activity register writes: set bits win, zero clears, other addresses leave it alone
  a_flag_write: assert property (s_write_data(ADDR_ACTIVITY)
    |=> (flags & $past(buf_word.data) & ACTIVITY_IMPL_MASK) == ($past(buf_word.data) & ACTIVITY_IMPL_MASK))
    else $error("written activity bits not stored");

  a_flag_clear: assert property (s_write_data(ADDR_ACTIVITY) ##0 buf_word.data == 8'h00 ##0 s_quiet_sets
    |=> flags == 8'h00)
    else $error("activity flags not cleared by zero write");

  a_write_ignored: assert property (data_byte && mode == MD_WRITE && addr != ADDR_ACTIVITY ##0 s_quiet_sets
    |=> flags == $past(flags))
    else $error("write to a read-only address changed the flags");

  a_write_once: assert property (data_byte && mode == MD_WRITE |=> mode == MD_IDLE)
    else $error("plain write took more than one data byte");

  a_read_snap: assert property (s_read_cmd(ADDR_ACTIVITY) |=> rd_val == $past(flags))
    else $error("activity read did not capture the flags");

  a_read_zero: assert property (is_first && !is_write_cmd && cmd_addr != ADDR_ACTIVITY
    && cmd_addr != ADDR_COMPL_CODE |=> rd_val == 8'h00)
    else $error("unmapped address did not read zero");

  // Flags stay clear without their source
  a_pd_quiet: assert property (!pd_pulse && !wr_act && !flags[FLAG_PD_PULSE] |=> !flags[FLAG_PD_PULSE])
    else $error("power-down flag set without a pulse");

  a_frame_quiet: assert property (!frame_tick && !wr_act && !flags[FLAG_FRAME_A] |=> !flags[FLAG_FRAME_A])
    else $error("frame flag set without a frame tick");

  // Pixel port: data while the count lasts, zero after, index parked at the end
  a_pixel_data: assert property (mode == MD_PIXEL && !pix_done |=> tx_byte == $past(pixel_data))
    else $error("pixel byte not offered");

  a_pixel_tail: assert property (mode == MD_PIXEL && pix_done |=> tx_byte == 8'h00)
    else $error("pixel port not zero past the count");

  a_pixel_hold: assert property (s_burst_step(MD_PIXEL) ##0 pix_done |=> $stable(pixel_index))
    else $error("pixel index moved past the count");

  // Motion port: snapshot taken at the command, zeros after the last byte
  a_motion_snap: assert property (s_read_cmd(ADDR_MOTION_PORT) |=> snap == $past(motion_report))
    else $error("motion report not captured");

  a_motion_tail: assert property (mode == MD_MOTION && mot_idx == MOTION_BYTES |=> tx_byte == 8'h00)
    else $error("motion port not zero past the report");

  a_motion_stop: assert property (s_burst_step(MD_MOTION) ##0 mot_idx == MOTION_BYTES
    |=> mot_idx == MOTION_BYTES)
    else $error("motion index ran past the report");

  // Firmware stream and the receive path; a slow link must never fill the buffer
  a_fw_mode: assert property (is_first && is_write_cmd && cmd_addr == ADDR_FW_PORT |=> mode == MD_FIRMWARE)
    else $error("firmware port not selected");

  a_fw_quiet: assert property (!fw_take |=> !fw_valid)
    else $error("firmware strobe without a byte");

  a_no_overrun: assert property (rx_evt |-> buf_ready)
    else $error("received byte found the buffer full");

  a_overrun_sticky: assert property (link_overrun |=> link_overrun)
    else $error("overrun flag dropped before reset");

endmodule

// ---- tb/ssb_host_model.sv ----
// Host controller model: frames commands and bursts on the four-wire serial port
`timescale 1ns/1ps
module ssb_host_model import ssb_pkg::*; (
  output logic sclk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  localparam real HALF_NS = 7.5;
  logic [7:0] tx_buf [0:15];
  logic [7:0] rx_buf [0:15];
  logic oe_all;

  // Clock idles high and stands still outside frames
  initial begin
    sclk = 1'b1;
    chip_select_n = 1'b1;
    mosi = 1'b1;
    oe_all = 1'b0;
  end

  // One byte in mode 3: change on falling edge, sample on rising edge
  task automatic shift_byte(input logic [7:0] out_b, output logic [7:0] in_b);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = out_b[i];
      #(HALF_NS);
      sclk = 1'b1;
      in_b[i] = miso;
      oe_all = oe_all & miso_oe;
      #(HALF_NS);
    end
  endtask

  // One command per frame; the select drops between commands
  task automatic run_frame(input logic wr, input logic [6:0] addr, input int n);
    logic [7:0] got;
    chip_select_n = 1'b0;
    #(HALF_NS);
    shift_byte({wr, addr}, got);
    oe_all = 1'b1;
    if (!wr) begin
      #(ADDR_READ_GAP_NS); // Device needs time to fetch the first byte
    end
    for (int k = 0; k < n; k++) begin
      shift_byte(wr ? tx_buf[k] : 8'hFF, got);
      rx_buf[k] = got;
    end
    #(HALF_NS);
    chip_select_n = 1'b1;
    mosi = ~mosi;
    #(100.0); // Lets the core take the last byte before the next frame
  endtask
endmodule

// ---- tb/sensor_status_burst_registers_test.sv ----
// Self-checking bench for the sensor status and burst register block
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sensor_status_burst_registers_test import ssb_pkg::*; ;
  localparam logic [7:0] PART_CODE_TB = 8'hC3; // Arbitrary value
  localparam int PIX_TB = 6; // Short pixel burst keeps the run brief
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } ssb_row_t;
  logic core_clk, rst_n, power_down_n, frame_tick, firmware_running;
  logic sclk, chip_select_n, mosi, miso, miso_oe, fw_valid, link_overrun;
  ssb_motion_t motion_report;
  logic [7:0] pixel_data, fw_byte;
  logic [10:0] pixel_index;
  logic [7:0] fw_seen [$];
  int mismatches = 0;
  int tests_run = 0;
  // Optional write, then a read of the same address and its expected byte
  ssb_row_t rows [8] = '{
    '{1'b0, 7'h3D, 8'h00, 8'h00}, '{1'b0, 7'h3F, 8'h00, ~PART_CODE_TB},
    '{1'b0, 7'h3E, 8'h00, 8'h00}, '{1'b0, 7'h12, 8'h00, 8'h00},
    '{1'b1, 7'h3F, 8'hFF, ~PART_CODE_TB}, '{1'b1, 7'h3E, 8'hFF, 8'h00},
    '{1'b1, 7'h3D, 8'hFF, 8'hA3}, '{1'b1, 7'h3D, 8'h00, 8'h00}};

  always #2 core_clk = ~core_clk;

  // Pixel memory seen by the burst: value follows the index
  assign pixel_data = pixel_index[7:0] ^ 8'h3C;

  // Collect every firmware byte the core hands on
  always @(posedge core_clk) begin
    if (fw_valid === 1'b1) begin
      fw_seen.push_back(fw_byte);
    end
  end

  ssb_host_model host_u (
    .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  ssb_top #(.PART_CODE(PART_CODE_TB), .PIXEL_TOTAL(PIX_TB)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .chip_select_n(chip_select_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .power_down_n(power_down_n),
    .frame_tick(frame_tick), .firmware_running(firmware_running),
    .motion_report(motion_report), .pixel_data(pixel_data), .pixel_index(pixel_index),
    .fw_byte(fw_byte), .fw_valid(fw_valid), .link_overrun(link_overrun));

  task automatic report_and_stop();
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic pulse_frame();
    @(posedge core_clk);
    #1;
    frame_tick = 1'b1;
    @(posedge core_clk);
    #1;
    frame_tick = 1'b0;
  endtask

  task automatic write_flags(input logic [7:0] v);
    host_u.tx_buf[0] = v;
    host_u.run_frame(1'b1, ADDR_ACTIVITY, 1);
  endtask

  task automatic check_flags(input logic [7:0] exp);
    host_u.run_frame(1'b0, ADDR_ACTIVITY, 1);
    `CHK(host_u.rx_buf[0], exp)
  endtask

  // Hang guard: a stuck run still ends in the closing report
  initial begin
    repeat (50000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    power_down_n = 1'b1;
    frame_tick = 1'b0;
    firmware_running = 1'b0;
    motion_report = {8'h81, 8'h05, 8'hFB, 8'h44, 8'h01, 8'h2C, 8'h9E};
    repeat (12) @(posedge core_clk);
    #1;
    `CHK(fw_valid, 1'b0)
    `CHK(pixel_index, 11'h000)
    `CHK(miso_oe, 1'b0)
    `CHK(link_overrun, 1'b0)
    rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    // Register map walk from the table
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        write_flags_or_port(rows[i].addr, rows[i].data);
      end
      host_u.run_frame(1'b0, rows[i].addr, 1);
      `CHK(host_u.rx_buf[0], rows[i].exp)
      `CHK(host_u.oe_all, 1'b1)
    end
    // Frame flags are set and stay set until software clears them
    pulse_frame();
    check_flags(8'h03);
    check_flags(8'h03);
    // Power-down pulse plus running firmware, then a clear while it still runs
    @(posedge core_clk);
    #1;
    power_down_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    power_down_n = 1'b1;
    firmware_running = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    check_flags(8'hA3);
    write_flags(8'h00);
    check_flags(8'h80);
    firmware_running = 1'b0;
    write_flags(8'h00);
    check_flags(8'h00);
    // Motion burst: seven report bytes in order, then zeros
    host_u.run_frame(1'b0, ADDR_MOTION_PORT, 9);
    for (int k = 0; k < 9; k++) begin
      `CHK(host_u.rx_buf[k], k < 7 ? motion_report[55 - 8 * k -: 8] : 8'h00)
    end
    // Pixel burst runs past its count to show the index stops
    host_u.run_frame(1'b0, ADDR_PIXEL_PORT, PIX_TB + 2);
    for (int k = 0; k < PIX_TB + 2; k++) begin
      `CHK(host_u.rx_buf[k], k < PIX_TB ? (8'(k) ^ 8'h3C) : 8'h00)
    end
    `CHK(pixel_index, 11'(PIX_TB))
    // Back-to-back firmware bytes, including all-zero and all-one patterns
    host_u.tx_buf[0] = 8'h00;
    host_u.tx_buf[1] = 8'hFF;
    host_u.tx_buf[2] = 8'h5C;
    host_u.tx_buf[3] = 8'hA3;
    host_u.run_frame(1'b1, ADDR_FW_PORT, 4);
    `CHK(fw_seen.size(), 4)
    for (int k = 0; k < 4; k++) begin
      `CHK(fw_seen[k], host_u.tx_buf[k])
    end
    `CHK(host_u.oe_all, 1'b0)
    // A 15 ns link can never fill the buffer, so no overrun is expected
    `CHK(link_overrun, 1'b0)
    // Reset in mid-run wipes flags set just before it
    pulse_frame();
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check_flags(8'h00);
    `CHK(pixel_index, 11'h000)
    report_and_stop();
  end

  task automatic write_flags_or_port(input logic [6:0] a, input logic [7:0] v);
    host_u.tx_buf[0] = v;
    host_u.run_frame(1'b1, a, 1);
  endtask
endmodule
